// ---- rtl/gpmx_pkg.sv ----
// Constants, register map and source codes for the pin output multiplexer.
// ==================================================================
package gpmx_pkg;

	// ==================================================================
	// Register offsets
	localparam logic [7:0] GPMX_OFS_PIN_DIR      = 8'h08;
	localparam logic [7:0] GPMX_OFS_PIN1_SEL     = 8'h52;
	localparam logic [7:0] GPMX_OFS_PIN0_SEL     = 8'h53;
	localparam logic [7:0] GPMX_OFS_PIN2_SEL     = 8'h55;
	localparam logic [7:0] GPMX_OFS_PIN_LEVEL    = 8'h56;
	localparam logic [7:0] GPMX_OFS_PIN_INVERT   = 8'h57;
	localparam logic [7:0] GPMX_OFS_OVF_STATUS   = 8'h5A;
	localparam logic [7:0] GPMX_OFS_CLOCK_FLEX   = 8'h5F;

	// ==================================================================
	// Field layout and reset values
	localparam int unsigned GPMX_SEL_W       = 5;
	localparam int unsigned GPMX_NPIN        = 3;
	localparam int unsigned GPMX_BIT_PIN0    = 3;
	localparam int unsigned GPMX_BIT_PIN1    = 2;
	localparam int unsigned GPMX_BIT_PIN2    = 5;
	localparam int unsigned GPMX_BIT_FLEX    = 0;
	localparam logic [7:0]  GPMX_PIN_MASK    = 8'h2C;
	localparam logic [7:0]  GPMX_OVF_MASK    = 8'h1F;
	localparam logic [7:0]  GPMX_RST_BYTE    = 8'h00;
	localparam logic [4:0]  GPMX_RST_SEL     = 5'h00;
	localparam int unsigned GPMX_OVF_SHIFTER = 0;
	localparam int unsigned GPMX_OVF_P2_A    = 1;
	localparam int unsigned GPMX_OVF_P2_B    = 2;
	localparam int unsigned GPMX_OVF_P1_A    = 3;
	localparam int unsigned GPMX_OVF_P1_B    = 4;

	// ==================================================================
	// Asynchronous status inputs, packed for the synchroniser
	localparam int unsigned GPMX_ASY_W       = 10;
	localparam int unsigned GPMX_ASY_AMUTE_A = 0;
	localparam int unsigned GPMX_ASY_AMUTE_B = 1;
	localparam int unsigned GPMX_ASY_CLKBAD  = 2;
	localparam int unsigned GPMX_ASY_ANA_A_N = 3;
	localparam int unsigned GPMX_ASY_ANA_B_N = 4;
	localparam int unsigned GPMX_ASY_PLLLOCK = 5;
	localparam int unsigned GPMX_ASY_CPCLK   = 6;
	localparam int unsigned GPMX_ASY_UV_HI   = 7;
	localparam int unsigned GPMX_ASY_UV_LO   = 8;
	localparam int unsigned GPMX_ASY_PLLOUT  = 9;

	// ==================================================================
	// Output source codes
	typedef enum logic [4:0] {
		GPMX_SRC_OFF       = 5'b00000,
		GPMX_SRC_DSP       = 5'b00001,
		GPMX_SRC_REG       = 5'b00010,
		GPMX_SRC_AMUTE_AB  = 5'b00011,
		GPMX_SRC_AMUTE_B   = 5'b00100,
		GPMX_SRC_AMUTE_A   = 5'b00101,
		GPMX_SRC_CLK_BAD   = 5'b00110,
		GPMX_SRC_SER_DATA  = 5'b00111,
		GPMX_SRC_ANAMUTE_B = 5'b01000,
		GPMX_SRC_ANAMUTE_A = 5'b01001,
		GPMX_SRC_PLL_LOCK  = 5'b01010,
		GPMX_SRC_CP_CLK    = 5'b01011,
		GPMX_SRC_UV_HI     = 5'b01110,
		GPMX_SRC_UV_LO     = 5'b01111,
		GPMX_SRC_PLL_DIV4  = 5'b10000
	} gpmx_src_t;

endpackage

// ---- rtl/gpmx_sync2.sv ----
// Two-flop synchroniser for a vector of independent level signals.
`timescale 1ns/10ps
`default_nettype none
module gpmx_sync2 #(
	parameter int unsigned WIDTH = 1
) (
	// Clock and reset
	input  wire logic             clk_sys,
	input  wire logic             sys_rst,
	// Data
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_q;

	// ==================================================================
	// Only the second stage is visible outside
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			meta_q   <= '0;
			sync_out <= '0;
		end else begin
			meta_q   <= async_in;
			sync_out <= meta_q;
		end
	end

endmodule
`default_nettype wire

// ---- rtl/gpmx_pin_mux.sv ----
// Source selection and polarity for one output pin.
`timescale 1ns/10ps
`default_nettype none
module gpmx_pin_mux
	import gpmx_pkg::*;
(
	// Configuration
	input  wire logic [4:0] sel,
	input  wire logic       sw_level,
	input  wire logic       invert,
	input  wire logic       clock_flex,
	// Sources
	input  wire logic       dsp_out,
	input  wire logic       amute_a,
	input  wire logic       amute_b,
	input  wire logic       clk_invalid,
	input  wire logic       ser_data,
	input  wire logic       anamute_a_n,
	input  wire logic       anamute_b_n,
	input  wire logic       pll_lock,
	input  wire logic       cp_clk,
	input  wire logic       uv_hi,
	input  wire logic       uv_lo,
	input  wire logic       pll_div4,
	// Result
	output logic            pin_val
);

	logic raw;

	// ==================================================================
	// Source select
	always_comb begin
		case (gpmx_src_t'(sel))
			GPMX_SRC_OFF:       raw = 1'b0;
			GPMX_SRC_DSP:       raw = dsp_out;
			GPMX_SRC_REG:       raw = sw_level;
			GPMX_SRC_AMUTE_AB:  raw = amute_a & amute_b;
			GPMX_SRC_AMUTE_B:   raw = amute_b;
			GPMX_SRC_AMUTE_A:   raw = amute_a;
			GPMX_SRC_CLK_BAD:   raw = clk_invalid;
			GPMX_SRC_SER_DATA:  raw = ser_data;
			GPMX_SRC_ANAMUTE_B: raw = anamute_b_n;
			GPMX_SRC_ANAMUTE_A: raw = anamute_a_n;
			GPMX_SRC_PLL_LOCK:  raw = pll_lock;
			GPMX_SRC_CP_CLK:    raw = cp_clk;
			GPMX_SRC_UV_HI:     raw = uv_hi;
			GPMX_SRC_UV_LO:     raw = uv_lo;
			// Without the flex setting the divided clock is not running
			GPMX_SRC_PLL_DIV4:  raw = pll_div4 & clock_flex;
			default:            raw = 1'b0;
		endcase
	end

	// Inversion sits after selection, so it also flips the off level
	assign pin_val = raw ^ invert;

endmodule
`default_nettype wire

// ---- rtl/gpmx_top.sv ----
// Output pin multiplexer and DSP overflow status, with its register port.
`timescale 1ns/10ps
`default_nettype none
module gpmx_top (
	// Clock and reset
	input  wire logic       clk_sys,
	input  wire logic       sys_rst,
	// Register port
	input  wire logic [7:0] reg_addr,
	input  wire logic       reg_wr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_rd,
	output logic      [7:0] reg_rdata,
	output logic            reg_rvalid,
	// DSP side, same clock
	input  wire logic       dsp_first_pin_out,
	input  wire logic       dsp_second_pin_out,
	input  wire logic       dsp_third_pin_out,
	input  wire logic       serial_audio_data_out,
	input  wire logic       ovf_port1_b,
	input  wire logic       ovf_port1_a,
	input  wire logic       ovf_port2_b,
	input  wire logic       ovf_port2_a,
	input  wire logic       ovf_shifter,
	// Status from other domains and analog
	input  wire logic       automute_a,
	input  wire logic       automute_b,
	input  wire logic       clock_invalid,
	input  wire logic       analog_mute_a_n,
	input  wire logic       analog_mute_b_n,
	input  wire logic       pll_lock,
	input  wire logic       charge_pump_clk,
	input  wire logic       speaker_mute_pin_above_07,
	input  wire logic       speaker_mute_pin_above_03,
	input  wire logic       pll_out,
	// Pins
	output logic            first_output_pin,
	output logic            first_output_pin_oe_n,
	output logic            second_output_pin,
	output logic            second_output_pin_oe_n,
	output logic            third_output_pin,
	output logic            third_output_pin_oe_n
);
	import gpmx_pkg::*;

	// ==================================================================
	// Declarations
	logic [4:0]            pin0_sel_q;
	logic [4:0]            pin1_sel_q;
	logic [4:0]            pin2_sel_q;
	logic [7:0]            level_q;
	logic [7:0]            invert_q;
	logic [7:0]            dir_q;
	logic                  flex_q;
	logic [7:0]            ovf_q;
	logic [7:0]            ovf_d;
	logic [7:0]            ovf_set;
	logic [7:0]            ovf_clr;
	logic [7:0]            rdata_d;
	logic                  rd_status;
	logic [GPMX_ASY_W-1:0] asy_raw;
	logic [GPMX_ASY_W-1:0] asy_s;
	logic                  pll_prev_q;
	logic [1:0]            pll_cnt_q;
	logic                  pin0_val;
	logic                  pin1_val;
	logic                  pin2_val;

	// Write strobe for one offset
	function automatic logic wr_hit(input logic [7:0] ofs);
		return reg_wr && (reg_addr == ofs);
	endfunction

	// Selector field as stored, upper bits dropped
	function automatic logic [4:0] sel_field(input logic [7:0] data);
		return data[GPMX_SEL_W-1:0];
	endfunction

	// ==================================================================
	// Synchronise everything that is not on clk_sys
	// Each bit is an independent level, so bitwise syncing is safe
	assign asy_raw[GPMX_ASY_AMUTE_A] = automute_a;
	assign asy_raw[GPMX_ASY_AMUTE_B] = automute_b;
	assign asy_raw[GPMX_ASY_CLKBAD]  = clock_invalid;
	assign asy_raw[GPMX_ASY_ANA_A_N] = analog_mute_a_n;
	assign asy_raw[GPMX_ASY_ANA_B_N] = analog_mute_b_n;
	assign asy_raw[GPMX_ASY_PLLLOCK] = pll_lock;
	assign asy_raw[GPMX_ASY_CPCLK]   = charge_pump_clk;
	assign asy_raw[GPMX_ASY_UV_HI]   = speaker_mute_pin_above_07;
	assign asy_raw[GPMX_ASY_UV_LO]   = speaker_mute_pin_above_03;
	assign asy_raw[GPMX_ASY_PLLOUT]  = pll_out;

	gpmx_sync2 #(
		.WIDTH (GPMX_ASY_W)
	) u_sync (
		.clk_sys  (clk_sys),
		.sys_rst  (sys_rst),
		.async_in (asy_raw),
		.sync_out (asy_s)
	);

	// ==================================================================
	// PLL output divided by four
	// Sampled on clk_sys, so only a PLL output below half of 25 MHz
	// divides faithfully; faster clocks alias.
	// Edge detector resets to the idle level of the synchronised pin
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			pll_prev_q <= 1'b0;
		end else begin
			pll_prev_q <= asy_s[GPMX_ASY_PLLOUT];
		end
	end

	// Counts rising edges only while the flex setting is on
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			pll_cnt_q <= 2'h0;
		end else if (asy_s[GPMX_ASY_PLLOUT] && !pll_prev_q && flex_q) begin
			pll_cnt_q <= pll_cnt_q + 2'h1;
		end
	end

	// ==================================================================
	// Selector registers
	// Only the five select bits are kept; the rest read back as zero
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			pin0_sel_q <= GPMX_RST_SEL;
		end else if (wr_hit(GPMX_OFS_PIN0_SEL)) begin
			pin0_sel_q <= sel_field(reg_wdata);
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			pin1_sel_q <= GPMX_RST_SEL;
		end else if (wr_hit(GPMX_OFS_PIN1_SEL)) begin
			pin1_sel_q <= sel_field(reg_wdata);
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			pin2_sel_q <= GPMX_RST_SEL;
		end else if (wr_hit(GPMX_OFS_PIN2_SEL)) begin
			pin2_sel_q <= sel_field(reg_wdata);
		end
	end

	// ==================================================================
	// Level, inversion, direction and clock flex registers
	// Bits that belong to no pin, except the flex bit, are not stored and read back as zero
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			level_q <= GPMX_RST_BYTE;
		end else if (wr_hit(GPMX_OFS_PIN_LEVEL)) begin
			level_q <= reg_wdata & GPMX_PIN_MASK;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			invert_q <= GPMX_RST_BYTE;
		end else if (wr_hit(GPMX_OFS_PIN_INVERT)) begin
			invert_q <= reg_wdata & GPMX_PIN_MASK;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			dir_q <= GPMX_RST_BYTE;
		end else if (wr_hit(GPMX_OFS_PIN_DIR)) begin
			dir_q <= reg_wdata & GPMX_PIN_MASK;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			flex_q <= 1'b0;
		end else if (wr_hit(GPMX_OFS_CLOCK_FLEX)) begin
			flex_q <= reg_wdata[GPMX_BIT_FLEX];
		end
	end

	// ==================================================================
	// Overflow status
	// Each event lands on its own status bit; the upper bits never set
	always_comb begin
		ovf_set                   = GPMX_RST_BYTE;
		ovf_set[GPMX_OVF_P1_B]    = ovf_port1_b;
		ovf_set[GPMX_OVF_P1_A]    = ovf_port1_a;
		ovf_set[GPMX_OVF_P2_B]    = ovf_port2_b;
		ovf_set[GPMX_OVF_P2_A]    = ovf_port2_a;
		ovf_set[GPMX_OVF_SHIFTER] = ovf_shifter;
	end
	assign rd_status = reg_rd && (reg_addr == GPMX_OFS_OVF_STATUS);
	assign ovf_clr   = rd_status ? GPMX_OVF_MASK : GPMX_RST_BYTE;
	// An overflow arriving in the read cycle survives the clear
	assign ovf_d = ((ovf_q & ~ovf_clr) | ovf_set) & GPMX_OVF_MASK;

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			ovf_q <= GPMX_RST_BYTE;
		end else begin
			ovf_q <= ovf_d;
		end
	end

	// ==================================================================
	// Read path
	// Unmapped offsets read as zero
	always_comb begin
		case (reg_addr)
			GPMX_OFS_PIN_DIR:    rdata_d = dir_q;
			GPMX_OFS_PIN1_SEL:   rdata_d = {3'h0, pin1_sel_q};
			GPMX_OFS_PIN0_SEL:   rdata_d = {3'h0, pin0_sel_q};
			GPMX_OFS_PIN2_SEL:   rdata_d = {3'h0, pin2_sel_q};
			GPMX_OFS_PIN_LEVEL:  rdata_d = level_q;
			GPMX_OFS_PIN_INVERT: rdata_d = invert_q;
			GPMX_OFS_OVF_STATUS: rdata_d = ovf_q;
			GPMX_OFS_CLOCK_FLEX: rdata_d = {7'h00, flex_q};
			default:             rdata_d = GPMX_RST_BYTE;
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			reg_rvalid <= 1'b0;
		end else begin
			reg_rvalid <= reg_rd;
		end
	end

	// Read data hold until the next read
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			reg_rdata <= GPMX_RST_BYTE;
		end else if (reg_rd) begin
			reg_rdata <= rdata_d;
		end
	end

	// ==================================================================
	// Pin multiplexers
	gpmx_pin_mux u_mux0 (
		.sel         (pin0_sel_q),
		.sw_level    (level_q[GPMX_BIT_PIN0]),
		.invert      (invert_q[GPMX_BIT_PIN0]),
		.clock_flex  (flex_q),
		.dsp_out     (dsp_first_pin_out),
		.amute_a     (asy_s[GPMX_ASY_AMUTE_A]),
		.amute_b     (asy_s[GPMX_ASY_AMUTE_B]),
		.clk_invalid (asy_s[GPMX_ASY_CLKBAD]),
		.ser_data    (serial_audio_data_out),
		.anamute_a_n (asy_s[GPMX_ASY_ANA_A_N]),
		.anamute_b_n (asy_s[GPMX_ASY_ANA_B_N]),
		.pll_lock    (asy_s[GPMX_ASY_PLLLOCK]),
		.cp_clk      (asy_s[GPMX_ASY_CPCLK]),
		.uv_hi       (asy_s[GPMX_ASY_UV_HI]),
		.uv_lo       (asy_s[GPMX_ASY_UV_LO]),
		.pll_div4    (pll_cnt_q[1]),
		.pin_val     (pin0_val)
	);

	gpmx_pin_mux u_mux1 (
		.sel         (pin1_sel_q),
		.sw_level    (level_q[GPMX_BIT_PIN1]),
		.invert      (invert_q[GPMX_BIT_PIN1]),
		.clock_flex  (flex_q),
		.dsp_out     (dsp_second_pin_out),
		.amute_a     (asy_s[GPMX_ASY_AMUTE_A]),
		.amute_b     (asy_s[GPMX_ASY_AMUTE_B]),
		.clk_invalid (asy_s[GPMX_ASY_CLKBAD]),
		.ser_data    (serial_audio_data_out),
		.anamute_a_n (asy_s[GPMX_ASY_ANA_A_N]),
		.anamute_b_n (asy_s[GPMX_ASY_ANA_B_N]),
		.pll_lock    (asy_s[GPMX_ASY_PLLLOCK]),
		.cp_clk      (asy_s[GPMX_ASY_CPCLK]),
		.uv_hi       (asy_s[GPMX_ASY_UV_HI]),
		.uv_lo       (asy_s[GPMX_ASY_UV_LO]),
		.pll_div4    (pll_cnt_q[1]),
		.pin_val     (pin1_val)
	);

	gpmx_pin_mux u_mux2 (
		.sel         (pin2_sel_q),
		.sw_level    (level_q[GPMX_BIT_PIN2]),
		.invert      (invert_q[GPMX_BIT_PIN2]),
		.clock_flex  (flex_q),
		.dsp_out     (dsp_third_pin_out),
		.amute_a     (asy_s[GPMX_ASY_AMUTE_A]),
		.amute_b     (asy_s[GPMX_ASY_AMUTE_B]),
		.clk_invalid (asy_s[GPMX_ASY_CLKBAD]),
		.ser_data    (serial_audio_data_out),
		.anamute_a_n (asy_s[GPMX_ASY_ANA_A_N]),
		.anamute_b_n (asy_s[GPMX_ASY_ANA_B_N]),
		.pll_lock    (asy_s[GPMX_ASY_PLLLOCK]),
		.cp_clk      (asy_s[GPMX_ASY_CPCLK]),
		.uv_hi       (asy_s[GPMX_ASY_UV_HI]),
		.uv_lo       (asy_s[GPMX_ASY_UV_LO]),
		.pll_div4    (pll_cnt_q[1]),
		.pin_val     (pin2_val)
	);

	// ==================================================================
	// Pin drivers
	// An input-direction pin is released and its value held low.
	function automatic logic drive_val(input logic val, input logic out_en);
		return val & out_en;
	endfunction

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			first_output_pin      <= 1'b0;
			first_output_pin_oe_n <= 1'b1;
		end else begin
			first_output_pin      <= drive_val(pin0_val, dir_q[GPMX_BIT_PIN0]);
			first_output_pin_oe_n <= ~dir_q[GPMX_BIT_PIN0];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			second_output_pin      <= 1'b0;
			second_output_pin_oe_n <= 1'b1;
		end else begin
			second_output_pin      <= drive_val(pin1_val, dir_q[GPMX_BIT_PIN1]);
			second_output_pin_oe_n <= ~dir_q[GPMX_BIT_PIN1];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			third_output_pin      <= 1'b0;
			third_output_pin_oe_n <= 1'b1;
		end else begin
			third_output_pin      <= drive_val(pin2_val, dir_q[GPMX_BIT_PIN2]);
			third_output_pin_oe_n <= ~dir_q[GPMX_BIT_PIN2];
		end
	end

endmodule
`default_nettype wire

// ---- verification/gpmx_board.sv ----
// Board-side reader of the three output pins.
`timescale 1ns/10ps
`default_nettype none
module gpmx_board (
	// Pins from the device
	input  wire logic       first_output_pin,
	input  wire logic       first_output_pin_oe_n,
	input  wire logic       second_output_pin,
	input  wire logic       second_output_pin_oe_n,
	input  wire logic       third_output_pin,
	input  wire logic       third_output_pin_oe_n,
	// Levels on the board, index 0 is the first pin
	output logic      [2:0] lvl
);
	// ====
	// Pull-downs
	// A released pin reads low, never the last driven value
	assign lvl[0] = first_output_pin_oe_n ? 1'b0 : first_output_pin;
	assign lvl[1] = second_output_pin_oe_n ? 1'b0 : second_output_pin;
	assign lvl[2] = third_output_pin_oe_n ? 1'b0 : third_output_pin;
endmodule
`default_nettype wire

// ---- verification/gpmx_top_assertions.sv ----
// Port-level checker for the pin multiplexer and overflow status.
`timescale 1ns/10ps
`default_nettype none
module gpmx_chk (
	// Clock and reset
	input  wire logic       clk_sys,
	input  wire logic       sys_rst,
	// Register port
	input  wire logic [7:0] reg_addr,
	input  wire logic       reg_rd,
	input  wire logic [7:0] reg_rdata,
	input  wire logic       reg_rvalid,
	// Overflow events
	input  wire logic       ovf_port1_b,
	input  wire logic       ovf_port1_a,
	input  wire logic       ovf_port2_b,
	input  wire logic       ovf_port2_a,
	input  wire logic       ovf_shifter,
	// Pins
	input  wire logic       first_output_pin,
	input  wire logic       first_output_pin_oe_n,
	input  wire logic       second_output_pin,
	input  wire logic       second_output_pin_oe_n,
	input  wire logic       third_output_pin,
	input  wire logic       third_output_pin_oe_n
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	wire logic rd_st = reg_rd && reg_addr == 8'h5A;
	wire logic ovf_any = ovf_port1_b | ovf_port1_a | ovf_port2_b | ovf_port2_a | ovf_shifter;
	// ====
	// Properties
	property p_rvalid; reg_rd |=> reg_rvalid; endproperty
	property p_no_rvalid; !reg_rd |=> !reg_rvalid; endproperty
	property p_pin0_off; first_output_pin_oe_n |-> !first_output_pin; endproperty
	property p_pin1_off; second_output_pin_oe_n |-> !second_output_pin; endproperty
	property p_pin2_off; third_output_pin_oe_n |-> !third_output_pin; endproperty
	property p_p1b; ovf_port1_b ##1 rd_st |=> reg_rdata[4]; endproperty
	property p_p2a; ovf_port2_a ##1 rd_st |=> reg_rdata[1]; endproperty
	property p_shift; ovf_shifter ##1 rd_st |=> reg_rdata[0]; endproperty
	property p_clear; rd_st && !ovf_any ##1 rd_st |=> reg_rdata[4:0] == 5'h00; endproperty
	property p_rsvd; rd_st |=> reg_rdata[7:5] == 3'h0; endproperty
	// ====
	// Assertions
	a_rvalid: assert property (p_rvalid) else $error("no read answer");
	a_no_rvalid: assert property (p_no_rvalid) else $error("stray read answer");
	a_pin0_off: assert property (p_pin0_off) else $error("first pin high while released");
	a_pin1_off: assert property (p_pin1_off) else $error("second pin high while released");
	a_pin2_off: assert property (p_pin2_off) else $error("third pin high while released");
	a_p1b: assert property (p_p1b) else $error("port one B flag lost");
	a_p2a: assert property (p_p2a) else $error("port two A flag lost");
	a_shift: assert property (p_shift) else $error("shifter flag lost");
	a_clear: assert property (p_clear) else $error("flags not cleared by read");
	a_rsvd: assert property (p_rsvd) else $error("unused status bits set");
	// ====
	// Coverage
	c_clear: cover property (rd_st ##1 rd_st);
	c_drive: cover property (!third_output_pin_oe_n && third_output_pin);
	c_event: cover property (ovf_shifter ##1 rd_st);
endmodule
bind gpmx_top gpmx_chk u_chk (.clk_sys, .sys_rst, .reg_addr, .reg_rd, .reg_rdata, .reg_rvalid,
	.ovf_port1_b, .ovf_port1_a, .ovf_port2_b, .ovf_port2_a, .ovf_shifter,
	.first_output_pin, .first_output_pin_oe_n, .second_output_pin, .second_output_pin_oe_n,
	.third_output_pin, .third_output_pin_oe_n);
`default_nettype wire

// ---- verification/test_gpio_output_mux_overflow_flags.sv ----
// Self-checking bench for the pin multiplexer and overflow status.
`timescale 1ns/10ps
`default_nettype none
module test_gpio_output_mux_overflow_flags;
	logic        clk_sys, sys_rst, reg_wr, reg_rd, reg_rvalid, pll_out;
	logic [7:0]  reg_addr, reg_wdata, reg_rdata, iv;
	logic [11:0] s, v;
	logic [4:0]  ov;
	logic        p0, p0n, p1, p1n, p2, p2n, prv;
	logic [2:0]  lvl;
	int          n_fail, checks_done, tg;
	int          bp [3] = '{3, 2, 5};
	logic [7:0]  ra [8] = '{8'h08, 8'h52, 8'h53, 8'h55, 8'h56, 8'h57, 8'h5A, 8'h5F};
	logic [7:0]  rm [8] = '{8'h2C, 8'h1F, 8'h1F, 8'h1F, 8'h2C, 8'h2C, 8'h00, 8'h01};

	gpmx_top DUT (.clk_sys, .sys_rst, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata, .reg_rvalid,
		.dsp_first_pin_out(s[0]), .dsp_second_pin_out(s[0]), .dsp_third_pin_out(s[0]),
		.serial_audio_data_out(s[1]), .ovf_port1_b(ov[4]), .ovf_port1_a(ov[3]),
		.ovf_port2_b(ov[2]), .ovf_port2_a(ov[1]), .ovf_shifter(ov[0]),
		.automute_a(s[2]), .automute_b(s[3]), .clock_invalid(s[4]), .analog_mute_a_n(s[5]),
		.analog_mute_b_n(s[6]), .pll_lock(s[7]), .charge_pump_clk(s[8]),
		.speaker_mute_pin_above_07(s[9]), .speaker_mute_pin_above_03(s[10]), .pll_out,
		.first_output_pin(p0), .first_output_pin_oe_n(p0n), .second_output_pin(p1),
		.second_output_pin_oe_n(p1n), .third_output_pin(p2), .third_output_pin_oe_n(p2n));
	gpmx_board u_board (.first_output_pin(p0), .first_output_pin_oe_n(p0n), .second_output_pin(p1),
		.second_output_pin_oe_n(p1n), .third_output_pin(p2), .third_output_pin_oe_n(p2n), .lvl(lvl));

	// ====
	// Tasks
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	// Two reads on adjacent edges; ev pulses the overflow inputs on the first
	task automatic rdp(input logic [7:0] a, input logic [4:0] ev, input logic [7:0] e1, input logic [7:0] e2);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		ov <= ev;
		@(posedge clk_sys);
		ov <= 5'h00;
		@(negedge clk_sys);
		chk({7'h00, reg_rvalid}, 8'h01);
		chk(reg_rdata, e1);
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		@(negedge clk_sys);
		chk(reg_rdata, e2);
	endtask
	task automatic print_verdict();
		$display("Comparisons %0d, mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// Source index 11 is the software level; second pin gets it inverted
	function automatic logic ex(input logic [4:0] c, input logic [11:0] x, input int k);
		case (c)
			5'h01: return x[0];
			5'h02: return x[11] ^ (k == 1);
			5'h03: return x[2] & x[3];
			5'h04: return x[3];
			5'h05: return x[2];
			5'h06: return x[4];
			5'h07: return x[1];
			5'h08: return x[6];
			5'h09: return x[5];
			5'h0A: return x[7];
			5'h0B: return x[8];
			5'h0E: return x[9];
			5'h0F: return x[10];
			default: return 1'b0;
		endcase
	endfunction

	// ====
	// Clock and watchdog
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end
	initial begin
		repeat (20000) @(posedge clk_sys);
		n_fail++;
		print_verdict();
	end

	// ====
	// Tests
	initial begin
		sys_rst = 1'b1;
		{reg_wr, reg_rd, pll_out} = 3'b000;
		{reg_addr, reg_wdata} = 16'h0000;
		s = 12'h000;
		ov = 5'h00;
		repeat (5) @(posedge clk_sys);
		sys_rst <= 1'b0;
		@(negedge clk_sys);
		chk({5'h00, p2n, p1n, p0n}, 8'h07);
		chk({5'h00, lvl}, 8'h00);
		for (int i = 0; i < 8; i++) begin
			rdp(ra[i], 5'h00, 8'h00, 8'h00);
			wr(ra[i], 8'hFF);
			rdp(ra[i], 5'h00, rm[i], rm[i]);
		end
		wr(8'h40, 8'hFF);
		rdp(8'h40, 5'h00, 8'h00, 8'h00);
		wr(8'h5F, 8'h00);
		for (int n = 0; n < 2; n++) begin
			iv = n ? 8'h28 : 8'h00;
			wr(8'h57, iv);
			for (int c = 0; c < 32; c++) begin
				wr(8'h53, 8'(c));
				wr(8'h52, 8'(c));
				wr(8'h55, 8'(c));
				for (int j = 0; j < 5; j++) begin
					for (int i = 0; i < 12; i++) begin
						v[i] = (j == 4) || ((((i + 1) >> j) % 2) == 1);
					end
					@(posedge clk_sys);
					s <= v;
					wr(8'h56, {2'b00, v[11], 1'b0, v[11], ~v[11], 2'b00});
					repeat (4) @(posedge clk_sys);
					@(negedge clk_sys);
					for (int k = 0; k < 3; k++) begin
						chk({7'h00, lvl[k]}, {7'h00, ex(5'(c), v, k) ^ iv[bp[k]]});
					end
				end
			end
		end
		wr(8'h57, 8'h2C);
		wr(8'h08, 8'h04);
		repeat (3) @(posedge clk_sys);
		@(negedge clk_sys);
		chk({5'h00, lvl}, 8'h02);
		chk({5'h00, p2n, p1n, p0n}, 8'h05);
		wr(8'h08, 8'h2C);
		wr(8'h57, 8'h00);
		wr(8'h55, 8'h10);
		wr(8'h5F, 8'h01);
		tg = 0;
		prv = 1'b0;
		for (int c = 0; c < 80; c++) begin
			@(posedge clk_sys);
			if (c % 4 == 0) begin
				pll_out <= ~pll_out;
			end
			@(negedge clk_sys);
			if (c >= 16 && lvl[2] !== prv) begin
				tg++;
			end
			prv = lvl[2];
		end
		chk(8'(tg), 8'h04);
		for (int i = 0; i < 5; i++) begin
			rdp(8'h40, 5'(1 << i), 8'h00, 8'h00);
			repeat (6) @(posedge clk_sys);
			rdp(8'h5A, 5'h00, 8'(1 << i), 8'h00);
		end
		rdp(8'h5A, 5'h1F, 8'h00, 8'h1F);
		rdp(8'h5A, 5'h00, 8'h00, 8'h00);
		print_verdict();
	end
endmodule
`default_nettype wire
